//--- rtl/ptc_pkg.sv
// Shared constants for the two-channel count timer
package ptc_pkg;

	// Structure of the block
	localparam int          CH_COUNT   = 2;        // Channels, each with counter and comparator
	localparam int          CNT_W      = 16;       // Counter and compare width
	localparam int          PRESCALE_W = 14;       // Prescaler reaches the 1/16384 tap

	// Count source selector codes
	localparam logic [1:0]  SRC_INTERNAL_RC = 2'h0;  // Internal RC oscillator, reset choice
	localparam logic [1:0]  SRC_LOW_SPEED   = 2'h1;  // Low-speed oscillator
	localparam logic [1:0]  SRC_HIGH_SPEED  = 2'h2;  // High-speed oscillator
	localparam logic [1:0]  SRC_EXTERNAL    = 2'h3;  // External count clock pin

	// Prescale ratio limits
	localparam logic [3:0]  RATIO_MAX_FAST = 4'he;   // 1/16384, 0xf reserved
	localparam logic [3:0]  RATIO_MAX_LOW  = 4'h8;   // 1/256 on the low-speed source

	// Capture trigger edge codes
	localparam logic [1:0]  EDGE_NONE    = 2'h0;     // No trigger, reset choice
	localparam logic [1:0]  EDGE_RISING  = 2'h1;     // Rising edge
	localparam logic [1:0]  EDGE_FALLING = 2'h2;     // Falling edge
	localparam logic [1:0]  EDGE_BOTH    = 2'h3;     // Both edges

	// Reset and step values
	localparam logic [CNT_W-1:0]      COUNT_ZERO    = 16'h0000;  // Counter cleared value
	localparam logic [CNT_W-1:0]      COUNT_STEP    = 16'h0001;  // Counter increment
	localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 14'h0000;  // Prescaler reset value
	localparam logic [PRESCALE_W-1:0] PRESCALE_STEP = 14'h0001;  // Prescaler increment

	// Channel that owns the shared counter
	localparam int          SHARED_OWNER = 0;

	// Comparator/capture block mode
	typedef enum logic {
		PTC_MODE_COMPARE,
		PTC_MODE_CAPTURE
	} ptc_mode_t;

endpackage

//--- rtl/ptc_count_clock.sv
`timescale 1ns/1ps
`default_nettype none

// Per-channel count clock controller: source select, prescaler, gate
module ptc_count_clock
	import ptc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [1:0] countSourceSelect,
	input  wire logic [3:0] prescaleRatioSelect,
	input  wire logic       countClockGate,
	input  wire logic       internalRcTick,
	input  wire logic       highSpeedTick,
	input  wire logic       lowSpeedTick,
	input  wire logic       externalCountClockPin,
	output logic            countTick
);

	// Tap mask for a power-of-two ratio
	function automatic logic [PRESCALE_W-1:0] tapMask(input logic [3:0] ratio);
		logic [PRESCALE_W:0] one;
		one = {{PRESCALE_W{1'b0}}, 1'b1} << ratio;
		tapMask = one[PRESCALE_W-1:0] - PRESCALE_STEP;
	endfunction

	logic                  extSync1;        // First synchroniser stage
	logic                  extSync2;        // Second synchroniser stage
	logic                  extPrev;         // Delayed copy for edge detect
	logic [PRESCALE_W-1:0] prescale;        // Free-running prescaler
	logic                  sourceTick;      // Selected internal source tick
	logic                  ratioLegal;      // Ratio not reserved for this source
	logic                  extRise;         // Rising edge on external clock
	logic [PRESCALE_W-1:0] mask;            // Current tap mask
	logic [PRESCALE_W-1:0] next_prescale;
	logic                  next_countTick;

	// Source mux, tap and gate
	always_comb begin
		unique case (countSourceSelect)  // [RULE_10]
			SRC_INTERNAL_RC: sourceTick = internalRcTick;
			SRC_LOW_SPEED:   sourceTick = lowSpeedTick;
			SRC_HIGH_SPEED:  sourceTick = highSpeedTick;
			SRC_EXTERNAL:    sourceTick = 1'b0;
		endcase
		// Low-speed source tops out lower; reserved codes give no count
		if (countSourceSelect == SRC_LOW_SPEED) begin
			ratioLegal = (prescaleRatioSelect <= RATIO_MAX_LOW);  // [RULE_12]
		end else begin
			ratioLegal = (prescaleRatioSelect <= RATIO_MAX_FAST);  // [RULE_11]
		end
		mask = tapMask(prescaleRatioSelect);
		extRise = extSync2 & ~extPrev;  // [RULE_19]
		// Prescaler steps regardless of gate and ratio, so a ratio change needs no restart
		next_prescale = sourceTick ? prescale + PRESCALE_STEP : prescale;  // [RULE_20]
		if (!countClockGate) begin
			next_countTick = 1'b0;  // [RULE_13]
		end else if (countSourceSelect == SRC_EXTERNAL) begin
			next_countTick = extRise;  // [RULE_19]
		end else begin
			next_countTick = sourceTick & ratioLegal & ((prescale & mask) == mask);  // [RULE_20]
		end
	end

	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			extSync1  <= 1'b0;
			extSync2  <= 1'b0;
			extPrev   <= 1'b0;
			prescale  <= PRESCALE_ZERO;
			countTick <= 1'b0;
		end else begin
			extSync1  <= externalCountClockPin;  // [RULE_19]
			extSync2  <= extSync1;
			extPrev   <= extSync2;
			prescale  <= next_prescale;
			countTick <= next_countTick;
		end
	end

endmodule

`default_nettype wire

//--- rtl/ptc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01: Two channels, sixteen-bit up counters each.
// RULE_02: Software runs, stops and clears each counter.
// RULE_03: Compare B match clears the counter.
// RULE_04: Counter equal to compare value raises match.
// RULE_05: Output pins driven from compare matches.
// RULE_06: Capture edge copies counter into capture register.
// RULE_07: Block is comparator or capture, never both.
// RULE_08: Enabled events raise an interrupt request.
// RULE_09: One counter may feed other channel's block.
// RULE_10: Source code selects pin, fast, slow, RC.
// RULE_11: Divide by two to the ratio field.
// RULE_12: Low-speed source allows at most 1/256.
// RULE_13: Gate bit zero blocks count clock.
// RULE_14: Each channel has its own clock controller.
// RULE_15: Count clock independent of processor clock.
// RULE_16: Trigger and output pins act after function select.
// RULE_17: Edge field: both, falling, rising, none.
// RULE_18: Shared counter mode uses channel 0 clock.
// RULE_19: External clock synchronised, counts rising edges.
// RULE_20: Free-running prescaler tap gives count enable.

// Datapath in brief
// Controller: source, prescaler, gate.
// Counter steps on its controller's enable.
// Compare block: matches and pin waveforms.
// Capture block: trigger edge copies count.
// Requests are pulses; no sticky flags,
// so software must catch each one.

// Timing
// Count enable one cycle after its tick.
// Counter and match flops move together.
// Clear wins over a count step.
// Capture takes the count before the step.
module ptc_timer
	import ptc_pkg::*;
(
	// Single clock, synchronous reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,

	// Oscillator ticks, one cycle each
	input  wire logic                           internalRcTick,
	input  wire logic                           highSpeedTick,
	input  wire logic                           lowSpeedTick,

	// Clock controller settings
	// Per channel, plus shared mode
	input  wire logic [CH_COUNT-1:0][1:0]       countSourceSelect,
	input  wire logic [CH_COUNT-1:0][3:0]       prescaleRatioSelect,
	input  wire logic [CH_COUNT-1:0]            countClockGate,
	input  wire logic                           sharedCounterMode,

	// Counter control
	input  wire logic [CH_COUNT-1:0]            countRun,
	input  wire logic [CH_COUNT-1:0]            counterClear,

	// Comparator/capture settings
	// Mode bit picks the block's role
	input  wire logic [CH_COUNT-1:0]            captureModeSelect,
	input  wire logic [CH_COUNT-1:0][CNT_W-1:0] compareValueA,
	input  wire logic [CH_COUNT-1:0][CNT_W-1:0] compareValueB,
	input  wire logic [CH_COUNT-1:0][1:0]       captureAEdgeSelect,
	input  wire logic [CH_COUNT-1:0][1:0]       captureBEdgeSelect,
	input  wire logic [CH_COUNT-1:0]            interruptEnableA,
	input  wire logic [CH_COUNT-1:0]            interruptEnableB,
	input  wire logic [CH_COUNT-1:0]            pinFunctionTimer,

	// Pins
	// Levels, sampled on clk_sys
	input  wire logic [CH_COUNT-1:0]            external_count_clock_pin,
	input  wire logic [CH_COUNT-1:0]            capture_a_trigger_pin,
	input  wire logic [CH_COUNT-1:0]            capture_b_trigger_pin,
	output logic      [CH_COUNT-1:0]            timer_output_a_pin,
	output logic      [CH_COUNT-1:0]            timer_output_b_pin,

	// Status toward software and interrupt controller
	// Matches and requests are pulses
	output logic      [CH_COUNT-1:0][CNT_W-1:0] counterValue,
	output logic      [CH_COUNT-1:0][CNT_W-1:0] captureValueA,
	output logic      [CH_COUNT-1:0][CNT_W-1:0] captureValueB,
	output logic      [CH_COUNT-1:0]            compareMatchA,
	output logic      [CH_COUNT-1:0]            compareMatchB,
	output logic      [CH_COUNT-1:0]            interruptRequest
);

	// Edge decode shared by both trigger inputs
	function automatic logic edgeHit(input logic [1:0] sel, input logic prev,
	                                 input logic cur);
		// Prev is last cycle's pin level
		unique case (sel)
			EDGE_NONE:    edgeHit = 1'b0;
			EDGE_RISING:  edgeHit = cur & ~prev;
			EDGE_FALLING: edgeHit = ~cur & prev;
			EDGE_BOTH:    edgeHit = cur ^ prev;
		endcase
	endfunction

	// Counter feeding a given comparator/capture block
	function automatic int counterFor(input int blk, input logic shared);
		// Shared mode: owner's counter for all
		counterFor = shared ? SHARED_OWNER : blk;
	endfunction

	// Per-channel state and decode
	logic [CH_COUNT-1:0]            countTick;      // Count enable per controller
	logic [CH_COUNT-1:0][CNT_W-1:0] counter;        // Counter state
	logic [CH_COUNT-1:0]            trigPrevA;      // Previous trigger A level
	logic [CH_COUNT-1:0]            trigPrevB;      // Previous trigger B level

	// Events of this cycle
	logic [CH_COUNT-1:0]            matchA;         // Compare A hit this cycle
	logic [CH_COUNT-1:0]            matchB;         // Compare B hit this cycle
	logic [CH_COUNT-1:0]            capA;           // Capture A event this cycle
	logic [CH_COUNT-1:0]            capB;           // Capture B event this cycle

	// Decode kept for later processes
	logic [CH_COUNT-1:0]            wipe;           // Counter clear request
	ptc_mode_t [CH_COUNT-1:0]       blockMode;      // Mode of each block

	// Next values, registered below
	logic [CH_COUNT-1:0][CNT_W-1:0] next_counter;
	logic [CH_COUNT-1:0][CNT_W-1:0] next_captureValueA;
	logic [CH_COUNT-1:0][CNT_W-1:0] next_captureValueB;
	logic [CH_COUNT-1:0]            next_toutA;
	logic [CH_COUNT-1:0]            next_toutB;
	logic [CH_COUNT-1:0]            next_interruptRequest;
	logic [CH_COUNT-1:0]            next_trigPrevA;
	logic [CH_COUNT-1:0]            next_trigPrevB;

	// One clock controller per channel, so settings never interact
	// Ticks come in; controllers pick, divide and gate
	for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_clk
		ptc_count_clock u_clk (  // [RULE_14]
			.clk_sys               (clk_sys),
			.rst_n                 (rst_n),
			.countSourceSelect     (countSourceSelect[ch]),
			.prescaleRatioSelect   (prescaleRatioSelect[ch]),
			.countClockGate        (countClockGate[ch]),
			.internalRcTick        (internalRcTick),
			.highSpeedTick         (highSpeedTick),
			.lowSpeedTick          (lowSpeedTick),
			.externalCountClockPin (external_count_clock_pin[ch]),
			.countTick             (countTick[ch])
		);
	end

	// Match and capture events per block
	// Pure decode, no state of its own
	always_comb begin
		int src;
		src       = 0;
		// Idle blocks stay silent
		matchA    = '0;
		matchB    = '0;
		capA      = '0;
		capB      = '0;
		blockMode = '{default: PTC_MODE_COMPARE};

		for (int b = 0; b < CH_COUNT; b++) begin
			// Shared mode hangs every block on the owner's counter and clock
			src = counterFor(b, sharedCounterMode);  // [RULE_09] [RULE_18]
			// A single mode bit makes the two functions exclusive
			blockMode[b] = captureModeSelect[b] ? PTC_MODE_CAPTURE : PTC_MODE_COMPARE;  // [RULE_07]
			if (blockMode[b] == PTC_MODE_COMPARE) begin
				// Match is taken on the next count step while the counter holds the value
				matchA[b] = countRun[src] & countTick[src]
				          & (counter[src] == compareValueA[b]);  // [RULE_04]
				matchB[b] = countRun[src] & countTick[src]
				          & (counter[src] == compareValueB[b]);  // [RULE_04]
			end else if (pinFunctionTimer[b]) begin
				// Triggers ignored while the pin is still a port pin
				// Nor while the counter is stopped
				capA[b] = countRun[src]
				        & edgeHit(captureAEdgeSelect[b], trigPrevA[b],
				                  capture_a_trigger_pin[b]);  // [RULE_06] [RULE_16] [RULE_17]
				// Trigger B runs the same decode
				capB[b] = countRun[src]
				        & edgeHit(captureBEdgeSelect[b], trigPrevB[b],
				                  capture_b_trigger_pin[b]);  // [RULE_06] [RULE_16] [RULE_17]
			end
		end
	end

	// Counter next state
	always_comb begin
		int src;
		src  = 0;
		// Software clear first, then B matches
		wipe = counterClear;  // [RULE_02]
		for (int b = 0; b < CH_COUNT; b++) begin
			src = counterFor(b, sharedCounterMode);
			// B match wipes the counter it watched
			if (matchB[b]) begin
				wipe[src] = 1'b1;  // [RULE_03]
			end
		end

		// One decision per counter
		for (int c = 0; c < CH_COUNT; c++) begin
			if (wipe[c]) begin
				// Clear wins over a count step in the same cycle
				next_counter[c] = COUNT_ZERO;  // [RULE_02] [RULE_03]
			end else if (countRun[c] && countTick[c]) begin
				// Count steps only on the enable, never on clk_sys itself
				next_counter[c] = counter[c] + COUNT_STEP;  // [RULE_01] [RULE_15]
			end else begin
				// Stopped counter keeps its value for a later resume
				next_counter[c] = counter[c];  // [RULE_02]
			end
		end
	end

	// Capture registers, outputs and interrupts
	always_comb begin
		int src;
		src = 0;
		next_captureValueA    = captureValueA;
		next_captureValueB    = captureValueB;
		next_toutA            = timer_output_a_pin;
		next_toutB            = timer_output_b_pin;
		next_interruptRequest = '0;
		// Pin levels kept for the next compare
		next_trigPrevA        = capture_a_trigger_pin;
		next_trigPrevB        = capture_b_trigger_pin;

		for (int b = 0; b < CH_COUNT; b++) begin
			src = counterFor(b, sharedCounterMode);
			// Value captured is the counter before this cycle's step
			if (capA[b]) begin
				next_captureValueA[b] = counter[src];  // [RULE_06]
			end
			if (capB[b]) begin
				next_captureValueB[b] = counter[src];  // [RULE_06]
			end

			// Output waveform
			if (!pinFunctionTimer[b] || blockMode[b] == PTC_MODE_CAPTURE) begin
				// Port pin or capture mode: no waveform, outputs parked low
				next_toutA[b] = 1'b0;  // [RULE_16]
				next_toutB[b] = 1'b0;  // [RULE_16]
			end else begin
				// A: high from period start to compare A, giving PWM
				if (matchB[b]) begin
					next_toutA[b] = 1'b1;  // [RULE_05]
				end else if (matchA[b]) begin
					next_toutA[b] = 1'b0;  // [RULE_05]
				end
				// B: toggles each period, a clock at half the period rate
				// Reset leaves it low; first B match raises it
				if (matchB[b]) begin
					next_toutB[b] = ~timer_output_b_pin[b];  // [RULE_05]
				end
			end
			// Request is a one-cycle pulse per cycle with any enabled event
			// Capture events share the A and B enables
			next_interruptRequest[b] = (interruptEnableA[b] & (matchA[b] | capA[b]))
			                         | (interruptEnableB[b] & (matchB[b] | capB[b]));  // [RULE_08]
		end
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		// Reset clears every flop; inputs need none
		if (!rst_n) begin
			counter            <= '0;
			captureValueA      <= '0;
			captureValueB      <= '0;
			timer_output_a_pin <= '0;
			timer_output_b_pin <= '0;
			compareMatchA      <= '0;
			compareMatchB      <= '0;
			interruptRequest   <= '0;
			trigPrevA          <= '0;
			trigPrevB          <= '0;
		end else begin
			// Every flop loads its next value
			counter            <= next_counter;
			captureValueA      <= next_captureValueA;
			captureValueB      <= next_captureValueB;
			timer_output_a_pin <= next_toutA;
			timer_output_b_pin <= next_toutB;
			// Match flops sample the decode directly
			compareMatchA      <= matchA;  // [RULE_04]
			compareMatchB      <= matchB;  // [RULE_04]
			interruptRequest   <= next_interruptRequest;
			trigPrevA          <= next_trigPrevA;
			trigPrevB          <= next_trigPrevB;
		end
	end

	// Counter value visible to software straight from its flops
	// No second copy, so no skew against matches
	assign counterValue = counter;

endmodule

`default_nettype wire

//--- verification/ptc_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Channel 0 port checks; channel 1 is judged by the bench
module ptc_timer_checker
	import ptc_pkg::*;
(
	input wire logic                           clk_sys,
	input wire logic                           rst_n,
	input wire logic [CH_COUNT-1:0]            countClockGate,
	input wire logic [CH_COUNT-1:0]            countRun,
	input wire logic [CH_COUNT-1:0]            counterClear,
	input wire logic [CH_COUNT-1:0]            captureModeSelect,
	input wire logic [CH_COUNT-1:0]            pinFunctionTimer,
	input wire logic [CH_COUNT-1:0]            interruptEnableA,
	input wire logic [CH_COUNT-1:0]            interruptEnableB,
	input wire logic [CH_COUNT-1:0][CNT_W-1:0] compareValueA,
	input wire logic [CH_COUNT-1:0][CNT_W-1:0] compareValueB,
	input wire logic [CH_COUNT-1:0][CNT_W-1:0] counterValue,
	input wire logic [CH_COUNT-1:0]            timer_output_a_pin,
	input wire logic [CH_COUNT-1:0]            timer_output_b_pin,
	input wire logic [CH_COUNT-1:0]            compareMatchA,
	input wire logic [CH_COUNT-1:0]            compareMatchB,
	input wire logic [CH_COUNT-1:0]            interruptRequest
);
	// One clock domain, so one default clock and reset
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_count_step: assert property ($changed(counterValue[0]) |->
		counterValue[0] == $past(counterValue[0]) + 16'h0001 || counterValue[0] == 16'h0000)
		else $error("counter moved other than up or to zero");
	a_clear_zero: assert property (counterClear[0] |=> counterValue[0] == 16'h0000)
		else $error("clear left counter nonzero");
	a_run_hold: assert property ((!countRun[0] && !counterClear[0])[*3] |=>
		$stable(counterValue[0])) else $error("stopped counter moved");
	a_gate_hold: assert property ((!countClockGate[0] && !counterClear[0])[*3] |=>
		$stable(counterValue[0])) else $error("gated counter moved");
	a_b_clears: assert property (compareMatchB[0] |-> counterValue[0] == 16'h0000)
		else $error("B match without counter clear");
	a_b_value: assert property (compareMatchB[0] |->
		$past(counterValue[0]) == $past(compareValueB[0])) else $error("B match at wrong count");
	a_a_value: assert property (compareMatchA[0] |->
		$past(counterValue[0]) == $past(compareValueA[0])) else $error("A match at wrong count");
	a_out_set: assert property (compareMatchB[0] && pinFunctionTimer[0] &&
		!captureModeSelect[0] |-> timer_output_a_pin[0])
		else $error("output A not set by B match");
	a_capture_quiet: assert property ((captureModeSelect[0] || !pinFunctionTimer[0])[*3]
		|-> !timer_output_a_pin[0] && !timer_output_b_pin[0]) else $error("output while not timer");
	a_irq_enabled: assert property (compareMatchA[0] && interruptEnableA[0] &&
		$past(interruptEnableA[0]) |-> interruptRequest[0]) else $error("enabled match lost");
	a_irq_masked: assert property ((!interruptEnableA[0] && !interruptEnableB[0])[*2]
		|-> !interruptRequest[0]) else $error("masked interrupt raised");
endmodule

bind ptc_timer ptc_timer_checker i_chk (.clk_sys, .rst_n, .countClockGate, .countRun,
	.counterClear, .captureModeSelect, .pinFunctionTimer, .interruptEnableA, .interruptEnableB,
	.compareValueA, .compareValueB, .counterValue, .timer_output_a_pin, .timer_output_b_pin,
	.compareMatchA, .compareMatchB, .interruptRequest);

`default_nettype wire

//--- verification/ptc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// Oscillator ticks and external count clock as seen at the timer
module ptc_pin_model
	import ptc_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                extRun,
	output logic                     internalRcTick,
	output logic                     highSpeedTick,
	output logic                     lowSpeedTick,
	output logic      [CH_COUNT-1:0] external_count_clock_pin
);
	logic [2:0] phase;  // Free-running oscillator phase

	initial phase = 3'h0;
	// Moves just after the edge, like any other driver
	always @(posedge clk_sys) begin
		#1 phase = phase + 3'h1;
	end
	// Rates unrelated to the counter settings: every 1, 2 and 4 cycles
	assign internalRcTick = 1'b1;
	assign highSpeedTick  = phase[0];
	assign lowSpeedTick   = (phase[1:0] == 2'h3);
	// Pin held 4 cycles per level so the synchroniser sees each edge; idles low
	assign external_count_clock_pin = extRun ? {CH_COUNT{phase[2]}} : '0;
endmodule

`default_nettype wire

//--- verification/ptc_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the two-channel count timer
module ptc_timer_tb
	import ptc_pkg::*;
;
	logic                           clk_sys, rst_n, sharedCounterMode, extRun;
	logic                           internalRcTick, highSpeedTick, lowSpeedTick;
	logic [CH_COUNT-1:0][1:0]       countSourceSelect, captureAEdgeSelect, captureBEdgeSelect;
	logic [CH_COUNT-1:0][3:0]       prescaleRatioSelect;
	logic [CH_COUNT-1:0]            countClockGate, countRun, counterClear, captureModeSelect;
	logic [CH_COUNT-1:0]            interruptEnableA, interruptEnableB, pinFunctionTimer;
	logic [CH_COUNT-1:0]            external_count_clock_pin, capture_a_trigger_pin;
	logic [CH_COUNT-1:0]            capture_b_trigger_pin, timer_output_a_pin, timer_output_b_pin;
	logic [CH_COUNT-1:0]            compareMatchA, compareMatchB, interruptRequest;
	logic [CH_COUNT-1:0][CNT_W-1:0] compareValueA, compareValueB, counterValue;
	logic [CH_COUNT-1:0][CNT_W-1:0] captureValueA, captureValueB;
	int                             mismatches, checks_done;

	ptc_timer     i_ptc_timer (.*);
	ptc_pin_model i_ptc_pin_model (.*);

	always #2.5 clk_sys = ~clk_sys;

	// Single comparison kind; unknown bits must match exactly
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Lands 1 ns past the edge, where drives and samples are safe
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Steps of both counters over w cycles; settle first for sync latency
	task automatic measure(input int w, output logic [15:0] d0, output logic [15:0] d1);
		logic [CNT_W-1:0] s0, s1;
		step(8);
		s0 = counterValue[0];
		s1 = counterValue[1];
		step(w);
		d0 = counterValue[0] - s0;
		d1 = counterValue[1] - s1;
	endtask
	task automatic clear0();
		counterClear[0] = 1'b1;
		step(1);
		counterClear[0] = 1'b0;
		check("cleared counter", 0, counterValue[0]);
	endtask
	// Edge on one trigger pin; hit says whether it must capture
	task automatic cap_try(input logic b, input logic lv, input logic hit, input string what);
		logic [CNT_W-1:0] old, snap;
		old = b ? captureValueB[0] : captureValueA[0];
		step(2);
		snap = counterValue[0];
		if (b) capture_b_trigger_pin[0] = lv;
		else capture_a_trigger_pin[0] = lv;
		step(3);
		check(what, hit ? snap : old, b ? captureValueB[0] : captureValueA[0]);
	endtask

	// Every source code on channel 0, channel 1 held at RC / 4
	task automatic t_sources();
		logic [15:0] d0, d1;
		countClockGate = 2'h3;
		countRun = 2'h3;
		extRun = 1'b1;
		prescaleRatioSelect[1] = 4'h2;
		for (int s = 0; s < 4; s++) begin
			countSourceSelect[0] = 2'(s);
			measure(64, d0, d1);
			check("source count", 64 / (s == 0 ? 1 : s == 1 ? 4 : s == 2 ? 2 : 8), d0);
			check("other channel", 16, d1);
		end
		$display("sources done");
	endtask
	// Power-of-two taps, reserved codes and the slow-source ceiling
	task automatic t_ratio();
		logic [15:0] d0, d1;
		countSourceSelect[0] = SRC_INTERNAL_RC;
		for (int n = 0; n < 5; n++) begin
			prescaleRatioSelect[0] = 4'(n);
			measure(64, d0, d1);
			check("ratio count", 64 >> n, d0);
		end
		prescaleRatioSelect[0] = 4'hf;
		measure(64, d0, d1);
		check("reserved ratio", 0, d0);
		countSourceSelect[0] = SRC_LOW_SPEED;
		prescaleRatioSelect[0] = RATIO_MAX_LOW;
		measure(2048, d0, d1);
		check("slow 1/256", 2, d0);
		prescaleRatioSelect[0] = 4'h9;
		measure(512, d0, d1);
		check("slow reserved", 0, d0);
		$display("ratio done");
	endtask
	// Gate, run and clear of channel 0
	task automatic t_stop();
		logic [15:0] d0, d1;
		countSourceSelect[0] = SRC_INTERNAL_RC;
		prescaleRatioSelect[0] = 4'h0;
		countClockGate[0] = 1'b0;
		measure(32, d0, d1);
		check("gate closed", 0, d0);
		countClockGate[0] = 1'b1;
		countRun[0] = 1'b0;
		measure(32, d0, d1);
		check("stopped", 0, d0);
		clear0();
		countRun[0] = 1'b1;
		measure(32, d0, d1);
		check("resumed", 32, d0);
		$display("stop done");
	endtask
	// Period B+1 with A=2, B=5: waveform, matches and interrupts
	task automatic t_compare();
		logic [31:0] nA, nB, hA, hB, irq, over;
		{nA, nB, hA, hB, irq, over} = '0;
		compareValueA[0] = 16'h0002;
		compareValueB[0] = 16'h0005;
		{interruptEnableA[0], interruptEnableB[0], pinFunctionTimer[0]} = 3'h7;
		clear0();
		step(12);
		for (int i = 0; i < 120; i++) begin
			step(1);
			nA = nA + compareMatchA[0];
			nB = nB + compareMatchB[0];
			hA = hA + timer_output_a_pin[0];
			hB = hB + timer_output_b_pin[0];
			irq = irq + interruptRequest[0];
			over = over + (counterValue[0] > 16'h0005);
		end
		check("match A count", 20, nA);
		check("match B count", 20, nB);
		check("count above B", 0, over);
		check("output A high", 60, hA);
		check("output B high", 60, hB);
		check("interrupts", 40, irq);
		$display("compare done");
	endtask
	// Edge codes on trigger A, both edges on B, then refused triggers
	task automatic t_capture();
		compareValueB[0] = 16'hffff;
		captureModeSelect[0] = 1'b1;
		for (int e = 0; e < 4; e++) begin
			captureAEdgeSelect[0] = 2'(e);
			cap_try(1'b0, 1'b1, e == 3 || e == 1, "capture A rise");
			cap_try(1'b0, 1'b0, e == 3 || e == 2, "capture A fall");
		end
		captureBEdgeSelect[0] = EDGE_BOTH;
		cap_try(1'b1, 1'b1, 1'b1, "capture B rise");
		cap_try(1'b1, 1'b0, 1'b1, "capture B fall");
		captureModeSelect[0] = 1'b0;
		cap_try(1'b0, 1'b1, 1'b0, "compare mode trigger");
		captureModeSelect[0] = 1'b1;
		pinFunctionTimer[0] = 1'b0;
		cap_try(1'b0, 1'b0, 1'b0, "port mode trigger");
		$display("capture done");
	endtask
	// Block 1 on counter 0 with its own clock gated off
	task automatic t_shared();
		logic [31:0] nB, over;
		{nB, over} = '0;
		captureModeSelect = 2'h0;
		compareValueB[1] = 16'h0003;
		countClockGate[1] = 1'b0;
		sharedCounterMode = 1'b1;
		clear0();
		step(12);
		for (int i = 0; i < 120; i++) begin
			step(1);
			nB = nB + compareMatchB[1];
			over = over + (counterValue[0] > 16'h0003);
		end
		check("shared B matches", 30, nB);
		check("shared count above B", 0, over);
		$display("shared done");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		{clk_sys, rst_n, sharedCounterMode, extRun, countSourceSelect, captureAEdgeSelect} = '0;
		{captureBEdgeSelect, prescaleRatioSelect, countClockGate, countRun, counterClear} = '0;
		{captureModeSelect, interruptEnableA, interruptEnableB, pinFunctionTimer} = '0;
		{capture_a_trigger_pin, capture_b_trigger_pin, compareValueA} = '0;
		compareValueB = '1;
		mismatches = 0;
		checks_done = 0;
		step(3);
		rst_n = 1'b1;
		step(1);
		check("counter after reset", 0, counterValue);
		t_sources();
		t_ratio();
		t_stop();
		t_compare();
		t_capture();
		t_shared();
		end_of_test();
	end
endmodule

`default_nettype wire
